// File: ttc_pkg.sv
/*
 * Constants for the triple timer/counter unit: register indices, field
 * positions, reset values and widths.
 * Assumes a 32-bit APB slave where byte address = 4 * register index.
 */
package ttc_pkg;

    // ****************************************
    // Register indices (byte address = index * 4)
    // ****************************************
    localparam int unsigned IDX_W          = 10;
    localparam logic [9:0]  IDX_A_COUNT    = 10'h001;
    localparam logic [9:0]  IDX_INT_CTRL   = 10'h00B;
    localparam logic [9:0]  IDX_IRQ_STATUS = 10'h00C;
    localparam logic [9:0]  IDX_B_LOW      = 10'h00E;
    localparam logic [9:0]  IDX_B_HIGH     = 10'h00F;
    localparam logic [9:0]  IDX_B_CTRL     = 10'h010;
    localparam logic [9:0]  IDX_C_COUNT    = 10'h011;
    localparam logic [9:0]  IDX_C_CTRL     = 10'h012;
    localparam logic [9:0]  IDX_OPTION     = 10'h081;
    localparam logic [9:0]  IDX_PB_DIR     = 10'h086;
    localparam logic [9:0]  IDX_IRQ_MASK   = 10'h08C;
    localparam logic [9:0]  IDX_C_PERIOD   = 10'h092;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned INT_A_FLAG_BIT = 2;
    localparam int unsigned INT_A_EN_BIT   = 5;
    localparam int unsigned OPT_SRC_BIT    = 5;
    localparam int unsigned OPT_EDGE_BIT   = 4;
    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam int unsigned B_RUN_BIT      = 0;
    localparam int unsigned B_CS_BIT       = 1;
    localparam int unsigned B_ASYNC_BIT    = 2;
    localparam int unsigned B_OSC_BIT      = 3;
    localparam int unsigned B_PS_LSB       = 4;
    localparam int unsigned C_PS_LSB       = 0;
    localparam int unsigned C_ON_BIT       = 2;
    localparam int unsigned C_POST_LSB     = 3;
    localparam int unsigned ST_A_BIT       = 0;
    localparam int unsigned ST_B_BIT       = 1;
    localparam int unsigned ST_C_BIT       = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  OPTION_RESET   = 8'hFF;
    localparam logic [7:0]  INT_CTRL_RESET = 8'h00;
    localparam logic [7:0]  PB_DIR_RESET   = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [2:0]  MASK_RESET     = 3'h0;

    // ****************************************
    // Count limits
    // ****************************************
    localparam logic [7:0]  A_MAX          = 8'hFF;
    localparam logic [15:0] B_MAX          = 16'hFFFF;

endpackage

// File: ttc_timer_unit.sv
/*
 * Triple timer/counter unit: 8-bit timer A with shared prescaler, 16-bit
 * timer/counter B, 8-bit period timer C, APB register slave, one interrupt.
 * Assumes CLK_SYS is the instruction-cycle clock; external clock pins are
 * asynchronous; SLEEP and CAPTURE_TRIGGER come from logic on CLK_SYS.
 */
// Register access over APB was chosen for this implementation.
// Summary of operation
// [R1] Timer A wrapping FF to 00 sets its overflow flag, interrupt control bit 2.
// [R2] Timer A interrupt is blocked while interrupt control bit 5 is clear.
// [R3] Timer A overflow flag stays set until software clears it.
// [R4] Timer A stops during sleep, so it cannot wake the processor.
// [R5] Option bit 3 assigns the shared prescaler to timer A or watchdog.
// [R6] Software moving prescaler to watchdog uses a safe instruction sequence.
// [R7] Timer B is a 16-bit count in readable, writable high and low bytes.
// [R8] Timer B wrapping FFFF to 0000 raises its interrupt flag.
// [R9] Timer B counts only while control bit 0 is set, else holds.
// [R10] Timer B offers timer, sync and async counter; bit 1 picks source.
// [R11] Timer mode counts each cycle; counter mode on external rising edges.
// [R12] Oscillator enable forces port B pins 2 and 1 to inputs.
// [R13] Capture/compare trigger clears the timer B count.
// [R14] Timer C has readable, writable 8-bit count and period registers.
// [R15] Timer C prescaler divides by 1, 4 or 16.
// [R16] Timer C postscaler divides by any ratio from 1 to 16.
// [R17] Timer C interrupt is count matching period, through the postscaler.
// [R18] Clearing timer C on bit (bit 2) stops timer C.
// [R19] On match timer C restarts from zero and advances postscaler.
`timescale 1ns/1ps

module ttc_timer_unit #(
    parameter int unsigned PADDR_WIDTH = 12
) (
    // Clock and reset
    input  wire logic                   CLK_SYS,
    input  wire logic                   RESET,
    // APB slave
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [PADDR_WIDTH-1:0] PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    // Core side
    input  wire logic                   SLEEP,
    input  wire logic                   CAPTURE_TRIGGER,
    // External clock pins
    input  wire logic                   TIMER_A_CLK_PIN,
    input  wire logic                   TIMER_B_CLK_PIN,
    // Outputs
    output logic                        IRQ,
    output logic                        PRESCALER_TO_WDT,
    output logic      [7:0]             PORT_B_DIR_OUT
);

    if (PADDR_WIDTH < 12)
    begin : g_bad_width
        $error("PADDR_WIDTH must be at least 12");
    end

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        a_s1;
        logic        a_s2;
        logic        a_s3;
        logic        b_s1;
        logic        b_s2;
        logic        b_s3;
        logic [7:0]  a_cnt;
        logic [7:0]  a_pre;
        logic [7:0]  int_ctrl;
        logic [7:0]  option;
        logic [15:0] b_cnt;
        logic [7:0]  b_ctrl;
        logic [2:0]  b_pre;
        logic        b_flag;
        logic [7:0]  c_cnt;
        logic [7:0]  c_per;
        logic [7:0]  c_ctrl;
        logic [3:0]  c_pre;
        logic [3:0]  c_post;
        logic        c_flag;
        logic [7:0]  pb_dir;
        logic [7:0]  pb_dir_out;
        logic [2:0]  irq_mask;
        logic        irq;
        logic        wdt_sel;
    } ttc_state_s;

    ttc_state_s q;
    ttc_state_s d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic ps_hit(input logic [7:0] cnt, input logic [7:0] mask);
        ps_hit = ((cnt & mask) == mask);
    endfunction

    logic [9:0] idx;
    logic       addr_ok;
    logic       setup;
    logic       wr;
    logic       ev_a;
    logic       ev_b;
    logic       tick_a;
    logic       tick_b;
    logic       tick_c;
    logic       edge_a;
    logic       edge_b;
    logic       c_match;
    logic [7:0] a_mask;
    logic [7:0] b_mask;
    logic [7:0] c_mask;

    function automatic logic wr_at(input logic [9:0] i);
        wr_at = wr && (idx == i);
    endfunction

    assign idx     = PADDR[11:2];
    assign addr_ok = (PADDR[1:0] == 2'h0) && ((PADDR >> 12) == '0);
    assign setup   = PSEL && !PENABLE;
    assign wr      = PSEL && PENABLE && q.pready && PWRITE && !q.pslverr;

    // External edges, seen only from the second and third stages
    assign edge_a  = q.option[ttc_pkg::OPT_EDGE_BIT] ? (q.a_s3 && !q.a_s2) : (!q.a_s3 && q.a_s2);
    assign edge_b  = !q.b_s3 && q.b_s2;

    // Timer A: stopped in sleep, prescaled unless assigned to watchdog
    assign ev_a    = !SLEEP && (q.option[ttc_pkg::OPT_SRC_BIT] ? edge_a : 1'b1); // [R4]
    assign a_mask  = 8'((9'h002 << q.option[2:0]) - 9'h001);
    assign tick_a  = ev_a && (q.option[ttc_pkg::OPT_ASSIGN_BIT] || ps_hit(q.a_pre, a_mask)); // [R5]

    // Timer B: cycle or external edge; sync mode stops in sleep
    assign ev_b    = q.b_ctrl[ttc_pkg::B_RUN_BIT] // [R9]
                  && (q.b_ctrl[ttc_pkg::B_CS_BIT] ? edge_b : 1'b1) // [R10] [R11]
                  && (!SLEEP || (q.b_ctrl[ttc_pkg::B_CS_BIT] && q.b_ctrl[ttc_pkg::B_ASYNC_BIT]));
    assign b_mask  = {5'h00, 3'((4'h1 << q.b_ctrl[5:4]) - 4'h1)};
    assign tick_b  = ev_b && ps_hit({5'h00, q.b_pre}, b_mask);

    // Timer C: prescale 1, 4 or 16
    assign c_mask  = (q.c_ctrl[1:0] == 2'h0) ? 8'h00 : ((q.c_ctrl[1:0] == 2'h1) ? 8'h03 : 8'h0F); // [R15]
    assign tick_c  = q.c_ctrl[ttc_pkg::C_ON_BIT] && ps_hit({4'h0, q.c_pre}, c_mask); // [R18]
    assign c_match = tick_c && (q.c_cnt == q.c_per);

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        d = q;

        // APB: one registered answer, zero wait states in the access phase
        d.pready  = setup;
        d.pslverr = 1'b0;
        d.prdata  = 32'h0000_0000;
        if (setup)
        begin
            d.pslverr = 1'b0;
            case (idx)
                ttc_pkg::IDX_A_COUNT:    d.prdata[7:0]  = q.a_cnt;
                ttc_pkg::IDX_INT_CTRL:   d.prdata[7:0]  = q.int_ctrl;
                ttc_pkg::IDX_IRQ_STATUS: d.prdata[2:0]  = {q.c_flag, q.b_flag, q.int_ctrl[ttc_pkg::INT_A_FLAG_BIT]};
                ttc_pkg::IDX_B_LOW:      d.prdata[7:0]  = q.b_cnt[7:0]; // [R7]
                ttc_pkg::IDX_B_HIGH:     d.prdata[7:0]  = q.b_cnt[15:8]; // [R7]
                ttc_pkg::IDX_B_CTRL:     d.prdata[7:0]  = q.b_ctrl;
                ttc_pkg::IDX_C_COUNT:    d.prdata[7:0]  = q.c_cnt; // [R14]
                ttc_pkg::IDX_C_CTRL:     d.prdata[7:0]  = q.c_ctrl;
                ttc_pkg::IDX_OPTION:     d.prdata[7:0]  = q.option;
                ttc_pkg::IDX_PB_DIR:     d.prdata[7:0]  = q.pb_dir;
                ttc_pkg::IDX_IRQ_MASK:   d.prdata[2:0]  = q.irq_mask;
                ttc_pkg::IDX_C_PERIOD:   d.prdata[7:0]  = q.c_per; // [R14]
                default:                 d.pslverr      = 1'b1;
            endcase
            if (!addr_ok)
            begin
                d.pslverr = 1'b1;
                d.prdata  = 32'h0000_0000;
            end
        end
        else if (PSEL && PENABLE && q.pready)
        begin
            d.pslverr = 1'b0;
        end
        else
        begin
            d.pslverr = q.pslverr && PSEL && PENABLE;
        end

        // Pin synchronisers
        d.a_s1 = TIMER_A_CLK_PIN;
        d.a_s2 = q.a_s1;
        d.a_s3 = q.a_s2;
        d.b_s1 = TIMER_B_CLK_PIN;
        d.b_s2 = q.b_s1;
        d.b_s3 = q.b_s2;

        // ****************************************
        // Timer A and shared prescaler
        // ****************************************
        if (ev_a && !q.option[ttc_pkg::OPT_ASSIGN_BIT])
        begin
            d.a_pre = q.a_pre + 8'h01;
        end
        if (tick_a)
        begin
            d.a_cnt = q.a_cnt + 8'h01;
        end
        if (wr_at(ttc_pkg::IDX_A_COUNT))
        begin
            d.a_cnt = PWDATA[7:0];
            d.a_pre = ttc_pkg::BYTE_ZERO;
        end
        if (wr_at(ttc_pkg::IDX_OPTION))
        begin
            d.option = PWDATA[7:0];
        end
        d.wdt_sel = d.option[ttc_pkg::OPT_ASSIGN_BIT]; // [R5]

        if (wr_at(ttc_pkg::IDX_INT_CTRL))
        begin
            d.int_ctrl = PWDATA[7:0];
        end
        if (wr_at(ttc_pkg::IDX_IRQ_STATUS) && PWDATA[ttc_pkg::ST_A_BIT])
        begin
            d.int_ctrl[ttc_pkg::INT_A_FLAG_BIT] = 1'b0;
        end
        if (tick_a && q.a_cnt == ttc_pkg::A_MAX)
        begin
            d.int_ctrl[ttc_pkg::INT_A_FLAG_BIT] = 1'b1; // [R1] [R3]
        end

        // ****************************************
        // Timer B
        // ****************************************
        if (ev_b)
        begin
            d.b_pre = q.b_pre + 3'h1;
        end
        if (tick_b)
        begin
            d.b_cnt = q.b_cnt + 16'h0001; // [R11]
        end
        if (CAPTURE_TRIGGER)
        begin
            d.b_cnt = 16'h0000; // [R13]
            d.b_pre = 3'h0;
        end
        if (wr_at(ttc_pkg::IDX_B_LOW))
        begin
            d.b_cnt[7:0] = PWDATA[7:0]; // [R7]
            d.b_pre      = 3'h0;
        end
        if (wr_at(ttc_pkg::IDX_B_HIGH))
        begin
            d.b_cnt[15:8] = PWDATA[7:0]; // [R7]
            d.b_pre       = 3'h0;
        end
        if (wr_at(ttc_pkg::IDX_B_CTRL))
        begin
            d.b_ctrl = PWDATA[7:0];
        end
        if (wr_at(ttc_pkg::IDX_IRQ_STATUS) && PWDATA[ttc_pkg::ST_B_BIT])
        begin
            d.b_flag = 1'b0;
        end
        if (tick_b && q.b_cnt == ttc_pkg::B_MAX && !CAPTURE_TRIGGER)
        begin
            d.b_flag = 1'b1; // [R8]
        end

        // ****************************************
        // Timer C
        // ****************************************
        if (q.c_ctrl[ttc_pkg::C_ON_BIT])
        begin
            d.c_pre = tick_c ? 4'h0 : q.c_pre + 4'h1;
        end
        if (tick_c)
        begin
            d.c_cnt = c_match ? ttc_pkg::BYTE_ZERO : q.c_cnt + 8'h01; // [R19]
        end
        if (c_match)
        begin
            d.c_post = (q.c_post == q.c_ctrl[6:3]) ? 4'h0 : q.c_post + 4'h1; // [R16] [R19]
        end
        if (wr_at(ttc_pkg::IDX_C_COUNT))
        begin
            d.c_cnt  = PWDATA[7:0]; // [R14]
            d.c_pre  = 4'h0;
            d.c_post = 4'h0;
        end
        if (wr_at(ttc_pkg::IDX_C_PERIOD))
        begin
            d.c_per = PWDATA[7:0]; // [R14]
        end
        if (wr_at(ttc_pkg::IDX_C_CTRL))
        begin
            d.c_ctrl = {1'b0, PWDATA[6:0]};
            d.c_pre  = 4'h0;
            d.c_post = 4'h0;
        end
        if (wr_at(ttc_pkg::IDX_IRQ_STATUS) && PWDATA[ttc_pkg::ST_C_BIT])
        begin
            d.c_flag = 1'b0;
        end
        if (c_match && q.c_post == q.c_ctrl[6:3])
        begin
            d.c_flag = 1'b1; // [R17]
        end

        // ****************************************
        // Port B direction and interrupt
        // ****************************************
        if (wr_at(ttc_pkg::IDX_PB_DIR))
        begin
            d.pb_dir = PWDATA[7:0];
        end
        d.pb_dir_out = d.pb_dir;
        if (d.b_ctrl[ttc_pkg::B_OSC_BIT])
        begin
            d.pb_dir_out[2:1] = 2'h3; // [R12]
        end
        if (wr_at(ttc_pkg::IDX_IRQ_MASK))
        begin
            d.irq_mask = PWDATA[2:0];
        end
        d.irq = (d.int_ctrl[ttc_pkg::INT_A_FLAG_BIT] && d.int_ctrl[ttc_pkg::INT_A_EN_BIT] // [R2]
                 && d.irq_mask[ttc_pkg::ST_A_BIT])
             || (d.b_flag && d.irq_mask[ttc_pkg::ST_B_BIT])
             || (d.c_flag && d.irq_mask[ttc_pkg::ST_C_BIT]);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            q            <= '0;
            q.option     <= ttc_pkg::OPTION_RESET;
            q.int_ctrl   <= ttc_pkg::INT_CTRL_RESET;
            q.pb_dir     <= ttc_pkg::PB_DIR_RESET;
            q.pb_dir_out <= ttc_pkg::PB_DIR_RESET;
            q.irq_mask   <= ttc_pkg::MASK_RESET;
            q.wdt_sel    <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign PRDATA           = q.prdata;
    assign PREADY           = q.pready;
    assign PSLVERR          = q.pslverr;
    assign IRQ              = q.irq;
    assign PRESCALER_TO_WDT = q.wdt_sel;
    assign PORT_B_DIR_OUT   = q.pb_dir_out;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    logic a_clr;
    logic b_wr;
    assign a_clr = wr_at(ttc_pkg::IDX_INT_CTRL) || wr_at(ttc_pkg::IDX_IRQ_STATUS);
    assign b_wr  = wr_at(ttc_pkg::IDX_B_LOW) || wr_at(ttc_pkg::IDX_B_HIGH);

    sequence s_a_wrap;
        tick_a && q.a_cnt == 8'hFF && !wr_at(ttc_pkg::IDX_A_COUNT);
    endsequence
    sequence s_b_wrap;
        tick_b && q.b_cnt == 16'hFFFF && !CAPTURE_TRIGGER && !b_wr;
    endsequence

    AST_A_OVERFLOW: assert property (s_a_wrap |=> q.a_cnt == 8'h00 && q.int_ctrl[2]) // [R1]
        else $error("Timer A wrap did not set its flag");
    AST_A_GATED: assert property (!q.int_ctrl[5] && q.irq_mask[2:1] == 2'h0 |-> !IRQ) // [R2]
        else $error("Timer A interrupt not gated by enable");
    AST_A_STICKY: assert property (q.int_ctrl[2] && !a_clr |=> q.int_ctrl[2]) // [R3]
        else $error("Timer A flag lost without software clear");
    AST_A_SLEEP: assert property (SLEEP && !wr_at(ttc_pkg::IDX_A_COUNT) |=> $stable(q.a_cnt)) // [R4]
        else $error("Timer A counted during sleep");
    AST_A_NO_PRESCALE: assert property (q.option[3] && !q.option[5] && !SLEEP && !wr_at(ttc_pkg::IDX_A_COUNT)
                                        |=> q.a_cnt == $past(q.a_cnt) + 8'h01) // [R5]
        else $error("Timer A not at full rate with prescaler on watchdog");
    AST_B_OVERFLOW: assert property (s_b_wrap |=> q.b_cnt == 16'h0000 && q.b_flag) // [R8]
        else $error("Timer B wrap did not set its flag");
    AST_B_HOLD: assert property (!q.b_ctrl[0] && !CAPTURE_TRIGGER && !b_wr |=> $stable(q.b_cnt)) // [R9]
        else $error("Timer B counted while stopped");
    AST_B_TIMER: assert property (q.b_ctrl[1:0] == 2'h1 && q.b_ctrl[5:4] == 2'h0 && !SLEEP && !CAPTURE_TRIGGER
                                  && !b_wr |=> q.b_cnt == $past(q.b_cnt) + 16'h0001) // [R11]
        else $error("Timer B did not count each cycle");
    AST_B_PINS: assert property (q.b_ctrl[3] |-> PORT_B_DIR_OUT[2:1] == 2'h3) // [R12]
        else $error("Oscillator pins not forced to inputs");
    AST_B_TRIGGER: assert property (CAPTURE_TRIGGER && !b_wr |=> q.b_cnt == 16'h0000) // [R13]
        else $error("Trigger did not clear timer B");
    AST_C_OFF: assert property (!q.c_ctrl[2] && !wr_at(ttc_pkg::IDX_C_COUNT) |=> $stable(q.c_cnt)) // [R18]
        else $error("Timer C counted while off");
    AST_C_MATCH: assert property (c_match && !wr_at(ttc_pkg::IDX_C_COUNT) && !wr_at(ttc_pkg::IDX_C_CTRL)
                                  |=> q.c_cnt == 8'h00 && (q.c_flag || q.c_post != 4'h0)) // [R17] [R19]
        else $error("Timer C match did not restart count or advance postscaler");

endmodule

// File: ttc_timer_unit_bench.sv
/*
 * Self-checking bench for the triple timer/counter unit: APB read and write
 * tasks, then sequences of register calls with expected values.
 * Assumes ttc_pkg and ttc_timer_unit are compiled first; zero-wait APB slave.
 */
`timescale 1ns/1ps

module ttc_timer_unit_bench;

    // ****************************************
    // Signals and counters
    // ****************************************
    logic        clk_sys;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep;
    logic        trig;
    logic        a_pin;
    logic        b_pin;
    logic        irq;
    logic        to_wdt;
    logic [7:0]  pb_dir;
    int          err_total;
    int          comparisons;
    int          cycles;
    logic [31:0] rd;
    logic        er;

    `define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
        $display("Error %s expected %0h seen %0h", name, exp, got); end end

    ttc_timer_unit ttc_timer_unit_i (
        .CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SLEEP(sleep), .CAPTURE_TRIGGER(trig), .TIMER_A_CLK_PIN(a_pin), .TIMER_B_CLK_PIN(b_pin),
        .IRQ(irq), .PRESCALER_TO_WDT(to_wdt), .PORT_B_DIR_OUT(pb_dir)
    );

    // ****************************************
    // Clock, reset and timeout
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim();
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One transfer; answer taken at the rising edge where PREADY is high
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
        begin
            @(posedge clk_sys);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [9:0] idx, input logic [7:0] v);
        apb(1'b1, idx, {24'h000000, v});
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] v, input string name);
        apb(1'b0, idx, 32'h00000000);
        `CHK(name, {24'h000000, v}, rd)
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            b_pin <= 1'b1;
            cyc(4);
            b_pin <= 1'b0;
            cyc(4);
        end
        cyc(4);
    endtask

    // Cycles from enabling timer C to its interrupt, within a small window
    task automatic c_measure(input logic [7:0] ctrl, input int exp);
        int n;
        n = 0;
        wr_reg(ttc_pkg::IDX_C_CTRL, 8'h00);
        wr_reg(ttc_pkg::IDX_C_COUNT, 8'h00);
        wr_reg(ttc_pkg::IDX_IRQ_STATUS, 8'h07);
        wr_reg(ttc_pkg::IDX_C_CTRL, ctrl);
        while (irq !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("c_event_time", 1'b1, (n + 3 >= exp && n <= exp + 3))
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sleep, trig, a_pin, b_pin} = 4'h0;
        {err_total, comparisons, cycles} = '0;
        reset = 1'b1;
        cyc(8);
        reset <= 1'b0;
        rd_chk(ttc_pkg::IDX_OPTION, 8'hFF, "option_reset");
        rd_chk(ttc_pkg::IDX_PB_DIR, 8'hFF, "pb_dir_reset");
        rd_chk(ttc_pkg::IDX_INT_CTRL, 8'h00, "int_ctrl_reset");
        `CHK("to_wdt_reset", 1'b1, to_wdt)
        `CHK("irq_reset", 1'b0, irq)
        apb(1'b0, 10'h3FF, 32'h00000000);
        `CHK("unmapped_err", 1'b1, er)
        // Timer A overflow, enable, mask and sticky flag
        wr_reg(ttc_pkg::IDX_OPTION, 8'h08);
        wr_reg(ttc_pkg::IDX_IRQ_MASK, 8'h01);
        wr_reg(ttc_pkg::IDX_INT_CTRL, 8'h20);
        wr_reg(ttc_pkg::IDX_A_COUNT, 8'hF0);
        rd_chk(ttc_pkg::IDX_INT_CTRL, 8'h20, "a_flag_before");
        cyc(20);
        rd_chk(ttc_pkg::IDX_INT_CTRL, 8'h24, "a_flag_set");
        `CHK("a_irq", 1'b1, irq)
        cyc(30);
        rd_chk(ttc_pkg::IDX_INT_CTRL, 8'h24, "a_flag_sticky");
        wr_reg(ttc_pkg::IDX_INT_CTRL, 8'h04);
        cyc(2);
        `CHK("a_irq_disabled", 1'b0, irq)
        rd_chk(ttc_pkg::IDX_INT_CTRL, 8'h04, "a_flag_kept");
        wr_reg(ttc_pkg::IDX_IRQ_STATUS, 8'h01);
        rd_chk(ttc_pkg::IDX_INT_CTRL, 8'h00, "a_flag_clear");
        sleep <= 1'b1;
        wr_reg(ttc_pkg::IDX_A_COUNT, 8'h5A);
        cyc(20);
        rd_chk(ttc_pkg::IDX_A_COUNT, 8'h5A, "a_sleep_hold");
        sleep <= 1'b0;
        wr_reg(ttc_pkg::IDX_OPTION, 8'h00);
        cyc(1);
        `CHK("to_wdt_off", 1'b0, to_wdt)
        wr_reg(ttc_pkg::IDX_A_COUNT, 8'h00);
        cyc(20);
        rd_chk(ttc_pkg::IDX_A_COUNT, 8'h0A, "a_prescaled");
        wr_reg(ttc_pkg::IDX_A_COUNT, 8'h00);
        wr_reg(ttc_pkg::IDX_OPTION, 8'h08);
        cyc(1);
        `CHK("to_wdt_on", 1'b1, to_wdt)
        // Timer B bytes, run bit, wrap, trigger, counter modes
        wr_reg(ttc_pkg::IDX_B_LOW, 8'hFE);
        wr_reg(ttc_pkg::IDX_B_HIGH, 8'hFF);
        rd_chk(ttc_pkg::IDX_B_HIGH, 8'hFF, "b_high_rw");
        cyc(10);
        rd_chk(ttc_pkg::IDX_B_LOW, 8'hFE, "b_low_hold");
        wr_reg(ttc_pkg::IDX_IRQ_STATUS, 8'h07);
        wr_reg(ttc_pkg::IDX_IRQ_MASK, 8'h02);
        wr_reg(ttc_pkg::IDX_B_CTRL, 8'h01);
        cyc(5);
        apb(1'b0, ttc_pkg::IDX_IRQ_STATUS, 32'h00000000);
        `CHK("b_wrap_flag", 32'h00000002, rd & 32'h00000002)
        `CHK("b_irq", 1'b1, irq)
        wr_reg(ttc_pkg::IDX_B_CTRL, 8'h00);
        trig <= 1'b1;
        cyc(1);
        trig <= 1'b0;
        rd_chk(ttc_pkg::IDX_B_LOW, 8'h00, "b_trig_low");
        rd_chk(ttc_pkg::IDX_B_HIGH, 8'h00, "b_trig_high");
        wr_reg(ttc_pkg::IDX_B_CTRL, 8'h03);
        pulses(5);
        rd_chk(ttc_pkg::IDX_B_LOW, 8'h05, "b_sync_count");
        sleep <= 1'b1;
        wr_reg(ttc_pkg::IDX_B_CTRL, 8'h07);
        pulses(3);
        rd_chk(ttc_pkg::IDX_B_LOW, 8'h08, "b_async_count");
        sleep <= 1'b0;
        wr_reg(ttc_pkg::IDX_PB_DIR, 8'h00);
        wr_reg(ttc_pkg::IDX_B_CTRL, 8'h08);
        cyc(2);
        `CHK("pb_dir_forced", 8'h06, pb_dir)
        wr_reg(ttc_pkg::IDX_B_CTRL, 8'h00);
        cyc(2);
        `CHK("pb_dir_free", 8'h00, pb_dir)
        // Timer C registers, prescaler, postscaler, on bit
        wr_reg(ttc_pkg::IDX_C_PERIOD, 8'h03);
        rd_chk(ttc_pkg::IDX_C_PERIOD, 8'h03, "c_period_rw");
        wr_reg(ttc_pkg::IDX_C_COUNT, 8'h02);
        rd_chk(ttc_pkg::IDX_C_COUNT, 8'h02, "c_count_rw");
        wr_reg(ttc_pkg::IDX_IRQ_MASK, 8'h04);
        c_measure(8'h04, 4);
        c_measure(8'h05, 16);
        c_measure(8'h06, 64);
        c_measure(8'h1C, 16);
        c_measure(8'h7C, 64);
        wr_reg(ttc_pkg::IDX_C_CTRL, 8'h00);
        wr_reg(ttc_pkg::IDX_C_COUNT, 8'h07);
        cyc(20);
        rd_chk(ttc_pkg::IDX_C_COUNT, 8'h07, "c_off_hold");
        end_sim();
    end

endmodule
